// ===== hdl/rot_consts.vh
// offsets, field positions, reset values and timing counts of the oscillator tune block
`ifndef ROT_CONSTS_VH
`define ROT_CONSTS_VH

`define ROT_ADDR_W 8
`define ROT_DATA_W 32
`define ROT_OFS_CTRL 8'h00
`define ROT_OFS_TRIM_PRI 8'h04
`define ROT_OFS_TRIM_SEQ 8'h08

`define ROT_BIT_SWEN 0
`define ROT_BIT_CF 3
`define ROT_BIT_SEQEN 6
`define ROT_BIT_DITHEN 7
`define ROT_BIT_REQPRI 8
`define ROT_BIT_SHUTOFF 11
`define ROT_COSC_LO 12
`define ROT_COSC_HI 14

`define ROT_OSC_FAST 3'h0
`define ROT_POSC_EXT 2'h0
`define ROT_POSC_XTAL 2'h2
`define ROT_LFSR_SEED 15'h0001

`define ROT_CLK_NS 20
`define ROT_FAIL_TIMEOUT_NS 10000
`define ROT_FAIL_CYCLES (`ROT_FAIL_TIMEOUT_NS / `ROT_CLK_NS)

`endif

// ===== hdl/rot_top.v
// fast rc oscillator trim, dither, clock switch and fail-safe monitor
`include "rot_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// R01 - fast oscillator runs unless external or crystal mode, or after fail switch
// R02 - range control picks low or high nominal frequency band
// R03 - 4-bit trim comes from primary or sequence trim per sequencing enable
// R04 - sequencing off: only the user trim field sets frequency; the code lets dither enable override it with the lfsr
// R05 - sequencing on: rollover counter bits 5 to 3 pick one of eight trims
// R06 - pwm advances its rollover counter once per time base rollover
// R07 - dither mode: 15-bit lfsr, lowest four bits drive trim
// R08 - dither active only while dither enable bit is set
// R09 - lfsr steps once per change of rollover counter bit 3
// R10 - config 1x disables clock switching and fail-safe monitor
// R11 - monitor enabled and oscillator fails: trap and move to fast oscillator
// R12 - on failure load current field with fast, set fail flag, clear switch enable
// R13 - failure leaves the watchdog alone on its low power clock
// R14 - power-up timer expiry before oscillator start traps and shuts oscillator off
// R15 - switching only between primary group and fast group, primary per config
// R16 - switching disabled: config selects, current field only reflects source
// R17 - software avoids switching below 100 kHz while monitor is enabled
// R18 - config 01 switching without monitor, 00 switching with monitor
// R19 - range config bit: 1 high range, 0 low range, oscillator and pll
// R20 - lfsr maximal length and nonzero seed so it never locks at zero
// R21 - mux index 0 is user trim, 1 to 7 sequence fields in order
module rot_top #(
  parameter FAIL_CYCLES = `ROT_FAIL_CYCLES
) (
  input wire CLK_SYS,
  input wire NRST,
  input wire [`ROT_ADDR_W-1:0] ADDR,
  input wire [`ROT_DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`ROT_DATA_W-1:0] RDATA,
  input wire [1:0] NEW_OSC_CONFIG,
  input wire [1:0] PRIMARY_OSC_MODE_CONFIG,
  input wire [1:0] SWITCH_MONITOR_CONFIG,
  input wire FREQ_RANGE_SELECT,
  input wire PRI_OSC_CLK,
  input wire PRI_OSC_STARTED,
  input wire POWER_UP_TIMER_DONE,
  input wire [5:0] PWM_ROLL,
  output reg [3:0] TRIM,
  output wire FREQ_RANGE_HIGH,
  output wire FAST_OSC_EN,
  output wire [2:0] CLK_SRC_SEL,
  output reg CLK_FAIL_TRAP,
  output wire PRI_OSC_OFF
);

  // idle counter width, wide enough for the longest fail window
  localparam CNT_W = 16;

  // clock switch state and control bits
  reg [`ROT_COSC_HI-`ROT_COSC_LO:0] cosc_r;
  reg swen_r;
  reg cf_r;
  reg seqen_r;
  reg dithen_r;
  reg reqpri_r;
  reg shutoff_r;
  reg init_r;

  // trim storage and dither state
  reg [3:0] user_trim_r;
  reg [27:0] seq_trim_r;
  reg [14:0] lfsr_r;
  reg roll3_prev_r;
  reg [3:0] trim_nxt;

  // pin synchroniser stages and settled levels
  reg [2:0] osc_sync_r;
  reg [2:0] power_up_timer_sync_r;
  reg [2:0] start_sync_r;
  reg osc_seen_r;
  reg start_seen_r;
  reg power_up_timer_prev_r;
  reg [CNT_W-1:0] idle_cnt_r;

  // decoded conditions
  wire stall_fail;
  wire start_fail;
  wire switch_on;
  wire monitor_on;
  wire [2:0] cfg_src;
  wire on_primary;
  wire osc_edge;
  wire osc_stall;
  wire power_up_timer_rise;
  wire fail_evt;
  wire wr_ctrl;
  wire [2:0] seq_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration decode
  assign switch_on = ~SWITCH_MONITOR_CONFIG[1]; // R10 R18
  assign monitor_on = (SWITCH_MONITOR_CONFIG == 2'h0); // R10 R18
  assign cfg_src = {1'b0, NEW_OSC_CONFIG};
  assign FREQ_RANGE_HIGH = FREQ_RANGE_SELECT; // R02 R19
  assign on_primary = (cosc_r != `ROT_OSC_FAST);
  // fast osc on when no primary mode picked, or when running from it
  assign FAST_OSC_EN = ((PRIMARY_OSC_MODE_CONFIG != `ROT_POSC_EXT) &&
                        (PRIMARY_OSC_MODE_CONFIG != `ROT_POSC_XTAL)) || ~on_primary; // R01
  // with switching off the config drives the mux, the field only mirrors it
  assign CLK_SRC_SEL = switch_on ? cosc_r : cfg_src; // R16
  assign PRI_OSC_OFF = shutoff_r;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, change counts once stages two and three agree
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      osc_sync_r <= 3'h0;
      power_up_timer_sync_r <= 3'h0;
      start_sync_r <= 3'h0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], PRI_OSC_CLK};
      power_up_timer_sync_r <= {power_up_timer_sync_r[1:0], POWER_UP_TIMER_DONE};
      start_sync_r <= {start_sync_r[1:0], PRI_OSC_STARTED};
    end
  end

  // one pulse per settled change of the primary clock pin
  assign osc_edge = (osc_sync_r[1] == osc_sync_r[2]) && (osc_sync_r[2] != osc_seen_r);
  assign power_up_timer_rise = (power_up_timer_sync_r[2] == power_up_timer_sync_r[1]) && power_up_timer_sync_r[2] && ~power_up_timer_prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // settled levels follow the pins only once stages two and three agree
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      osc_seen_r <= 1'b0;
      start_seen_r <= 1'b0;
    end else begin
      if (osc_sync_r[1] == osc_sync_r[2]) begin
        osc_seen_r <= osc_sync_r[2];
      end
      if (start_sync_r[1] == start_sync_r[2]) begin
        start_seen_r <= start_sync_r[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // primary clock activity watch
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      idle_cnt_r <= {CNT_W{1'b0}};
      power_up_timer_prev_r <= 1'b0;
    end else begin
      if (power_up_timer_sync_r[2] == power_up_timer_sync_r[1]) begin
        power_up_timer_prev_r <= power_up_timer_sync_r[2];
      end
      if (osc_edge || !on_primary || !monitor_on) begin
        idle_cnt_r <= {CNT_W{1'b0}};
      end else if (!osc_stall) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
    end
  end

  assign osc_stall = (idle_cnt_r >= FAIL_CYCLES[CNT_W-1:0]);
  // running oscillator went quiet for the whole window
  assign stall_fail = osc_stall; // R11
  // power-up timer ran out before the oscillator came up
  assign start_fail = power_up_timer_rise && !start_seen_r; // R14
  // watchdog has no input here, so a failure never touches it
  assign fail_evt = monitor_on && on_primary && switch_on && init_r &&
                    (stall_fail || start_fail); // R11 R13 R14

  ////////////////////////////////////////////////////////////////////////////////
  // control register and clock switch state
  assign wr_ctrl = WR && (ADDR == `ROT_OFS_CTRL);

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cosc_r <= `ROT_OSC_FAST;
      swen_r <= 1'b0;
      cf_r <= 1'b0;
      seqen_r <= 1'b0;
      dithen_r <= 1'b0;
      reqpri_r <= 1'b0;
      shutoff_r <= 1'b0;
      init_r <= 1'b0;
      CLK_FAIL_TRAP <= 1'b0;
    end else begin
      CLK_FAIL_TRAP <= fail_evt; // R11
      if (wr_ctrl) begin
        seqen_r <= WDATA[`ROT_BIT_SEQEN];
        dithen_r <= WDATA[`ROT_BIT_DITHEN]; // R08
        reqpri_r <= WDATA[`ROT_BIT_REQPRI];
      end
      // fail flag: software clears it, a new failure wins
      if (fail_evt) begin
        cf_r <= 1'b1; // R12
      end else if (wr_ctrl && !WDATA[`ROT_BIT_CF]) begin
        cf_r <= 1'b0;
      end
      if (!init_r) begin
        init_r <= 1'b1;
        cosc_r <= cfg_src;
        // a switch request on the very first edge is kept, not lost
        if (wr_ctrl && switch_on) begin
          swen_r <= WDATA[`ROT_BIT_SWEN];
        end
      end else if (fail_evt) begin
        cosc_r <= `ROT_OSC_FAST; // R12
        swen_r <= 1'b0; // R12
        shutoff_r <= 1'b1; // R14
      end else if (!switch_on) begin
        cosc_r <= cfg_src; // R16
        swen_r <= 1'b0; // R10
      end else if (swen_r) begin
        // group switch; inside the primary group the config decides
        cosc_r <= reqpri_r ? cfg_src : `ROT_OSC_FAST; // R15
        shutoff_r <= ~reqpri_r;
        swen_r <= 1'b0;
        // a second request while one waits is dropped
      end else if (wr_ctrl) begin
        swen_r <= WDATA[`ROT_BIT_SWEN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trim registers
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      user_trim_r <= 4'h0;
      seq_trim_r <= 28'h0000000;
    end else begin
      if (WR && (ADDR == `ROT_OFS_TRIM_PRI)) begin
        user_trim_r <= WDATA[3:0];
      end
      if (WR && (ADDR == `ROT_OFS_TRIM_SEQ)) begin
        seq_trim_r <= WDATA[27:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dither lfsr, x^15 + x^14 + 1, stepped on each rollover bit 3 change
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lfsr_r <= `ROT_LFSR_SEED; // R20
      roll3_prev_r <= 1'b0;
    end else begin
      roll3_prev_r <= PWM_ROLL[3];
      if (dithen_r && (PWM_ROLL[3] != roll3_prev_r)) begin
        lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]}; // R09 R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trim source select
  assign seq_idx = PWM_ROLL[5:3]; // R06

  // dither first, then the sequence, else the user trim
  always @* begin
    trim_nxt = user_trim_r; // R04
    if (dithen_r) begin
      trim_nxt = lfsr_r[3:0]; // R07 R08
    end else if (seqen_r) begin
      case (seq_idx)
        3'h0: trim_nxt = user_trim_r; // R21
        3'h1: trim_nxt = seq_trim_r[3:0];
        3'h2: trim_nxt = seq_trim_r[7:4];
        3'h3: trim_nxt = seq_trim_r[11:8];
        3'h4: trim_nxt = seq_trim_r[15:12];
        3'h5: trim_nxt = seq_trim_r[19:16];
        3'h6: trim_nxt = seq_trim_r[23:20];
        3'h7: trim_nxt = seq_trim_r[27:24]; // R05
        default: trim_nxt = user_trim_r;
      endcase
    end
  end

  // trim output register, one cycle behind the select
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      TRIM <= 4'h0;
    end else begin
      TRIM <= trim_nxt; // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe, zero elsewhere
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      // control word: current field, shut off, request, dither, sequence, fail, switch
      case (ADDR)
        `ROT_OFS_CTRL: RDATA <= {17'h00000, cosc_r, shutoff_r, 2'h0, reqpri_r, dithen_r, seqen_r,
                                 2'h0, cf_r, 2'h0, swen_r};
        `ROT_OFS_TRIM_PRI: RDATA <= {28'h0000000, user_trim_r};
        `ROT_OFS_TRIM_SEQ: RDATA <= {4'h0, seq_trim_r};
        default: RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end

endmodule

// ===== tb/rot_chk.sv
// port checker of the oscillator tune block
`include "rot_consts.vh"
module rot_chk #(parameter FAIL_CYCLES = 500) (
  input wire CLK_SYS,
  input wire NRST,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire [1:0] NEW_OSC_CONFIG,
  input wire [1:0] SWITCH_MONITOR_CONFIG,
  input wire FREQ_RANGE_SELECT,
  input wire [5:0] PWM_ROLL,
  input wire [3:0] TRIM,
  input wire FREQ_RANGE_HIGH,
  input wire FAST_OSC_EN,
  input wire [2:0] CLK_SRC_SEL,
  input wire CLK_FAIL_TRAP,
  input wire PRI_OSC_OFF
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  reg [3:0] usr_r;
  reg [31:0] seq_r;
  reg sen_r;
  reg den_r;
  reg sw_prev_r;
  wire [4:0] idx = {PWM_ROLL[5:3] - 3'h1, 2'b00};
  // a switch write one edge earlier leaves its request pending
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) sw_prev_r <= 1'b0;
    else sw_prev_r <= WR && ADDR == `ROT_OFS_CTRL && WDATA[`ROT_BIT_SWEN];
  end
  // software asks for the fast group while switching is allowed and none waits
  sequence fast_req_s;
    !SWITCH_MONITOR_CONFIG[1] && WR && ADDR == `ROT_OFS_CTRL && WDATA[`ROT_BIT_SWEN] &&
      !WDATA[`ROT_BIT_REQPRI] && !sw_prev_r;
  endsequence
  // two edges later the fast source runs and the primary is off
  sequence fast_done_s;
    ##2 (CLK_SRC_SEL == 3'h0 && PRI_OSC_OFF);
  endsequence
  wire [3:0] exp_trim = (!sen_r || PWM_ROLL[5:3] == 3'h0) ? usr_r : seq_r[idx +: 4];
  // shadow copy of trim and mode bits
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      usr_r <= 4'h0;
      seq_r <= 32'h0;
      sen_r <= 1'b0;
      den_r <= 1'b0;
    end else if (WR) begin
      if (ADDR == `ROT_OFS_CTRL) sen_r <= WDATA[`ROT_BIT_SEQEN];
      if (ADDR == `ROT_OFS_CTRL) den_r <= WDATA[`ROT_BIT_DITHEN];
      if (ADDR == `ROT_OFS_TRIM_PRI) usr_r <= WDATA[3:0];
      if (ADDR == `ROT_OFS_TRIM_SEQ) seq_r <= WDATA;
    end
  end
  // port relations
  range_follow_a: assert property (FREQ_RANGE_HIGH == FREQ_RANGE_SELECT) else $error("range bad");
  fast_power_a: assert property (CLK_SRC_SEL == 3'h0 |-> FAST_OSC_EN) else $error("fast osc off");
  cfg_select_a: assert property (SWITCH_MONITOR_CONFIG[1] |-> CLK_SRC_SEL == {1'b0, NEW_OSC_CONFIG})
    else $error("source not config");
  monitor_off_a: assert property (SWITCH_MONITOR_CONFIG != 2'b00 |-> !CLK_FAIL_TRAP) else $error("trap");
  trap_pulse_a: assert property (CLK_FAIL_TRAP |=> !CLK_FAIL_TRAP && CLK_SRC_SEL == 3'h0)
    else $error("trap pulse bad");
  trap_shut_a: assert property (CLK_FAIL_TRAP |=> PRI_OSC_OFF) else $error("osc not off");
  group_switch_a: assert property (fast_req_s |-> fast_done_s) else $error("group switch bad");
  trim_select_a: assert property (!den_r |=> TRIM == $past(exp_trim)) else $error("trim bad");
  dither_hold_a: assert property ((den_r && $stable(PWM_ROLL[3])) [*3] |-> $stable(TRIM))
    else $error("dither moved");
endmodule
bind rot_top rot_chk #(.FAIL_CYCLES(FAIL_CYCLES)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .NEW_OSC_CONFIG(NEW_OSC_CONFIG), .SWITCH_MONITOR_CONFIG(SWITCH_MONITOR_CONFIG),
  .FREQ_RANGE_SELECT(FREQ_RANGE_SELECT), .PWM_ROLL(PWM_ROLL), .TRIM(TRIM), .FREQ_RANGE_HIGH(FREQ_RANGE_HIGH),
  .FAST_OSC_EN(FAST_OSC_EN), .CLK_SRC_SEL(CLK_SRC_SEL), .CLK_FAIL_TRAP(CLK_FAIL_TRAP), .PRI_OSC_OFF(PRI_OSC_OFF));

// ===== tb/rot_far.sv
// pwm rollover counter and primary oscillator stand-in
module rot_far (
  input wire clk,
  input wire nrst,
  input wire osc_on,
  output logic [5:0] roll,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // three-cycle pwm period; oscillator far above 100 khz, halts when off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 2'h0;
      roll <= 6'h00;
      osc <= 1'b0;
    end else begin
      cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      if (cnt == 2'h2) roll <= roll + 6'h01;
      if (osc_on && cnt == 2'h0) osc <= ~osc;
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the oscillator tune block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, nrst = 0, wr = 0, rd = 0, started = 1, put_done = 0, osc_on = 1, osc, trap, fast_en, hi, off;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] smc = 0, pmc = 2'b10;
  logic frs = 1;
  logic [5:0] roll;
  logic [3:0] trim;
  logic [2:0] src;
  int miscompares = 0, checks = 0, i, n;
  rot_far far (.clk(clk_sys), .nrst(nrst), .osc_on(osc_on), .roll(roll), .osc(osc));
  rot_top #(.FAIL_CYCLES(20)) dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .NEW_OSC_CONFIG(2'b10), .PRIMARY_OSC_MODE_CONFIG(pmc), .SWITCH_MONITOR_CONFIG(smc),
    .FREQ_RANGE_SELECT(frs), .PRI_OSC_CLK(osc), .PRI_OSC_STARTED(started), .POWER_UP_TIMER_DONE(put_done),
    .PWM_ROLL(roll), .TRIM(trim), .FREQ_RANGE_HIGH(hi), .FAST_OSC_EN(fast_en), .CLK_SRC_SEL(src),
    .CLK_FAIL_TRAP(trap), .PRI_OSC_OFF(off));
  initial forever #10 clk_sys = ~clk_sys;
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    rd <= 1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 0;
    @(negedge clk_sys);
    chk(nm, rdata, e);
  endtask
  task rst(input logic [1:0] m, input logic s);
    @(posedge clk_sys);
    nrst <= 0;
    smc <= m;
    started <= s;
    put_done <= 0;
    osc_on <= 1;
    repeat (5) @(posedge clk_sys);
    nrst <= 1;
    repeat (2) @(posedge clk_sys);
  endtask
  task wtrap(input int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (trap !== 1'b1 && n < lim);
    chk("trap", trap, 1);
    repeat (2) @(negedge clk_sys);
    chk("src_trap", src, 0);
    chk("osc_off", off, 1);
  endtask
  task results;
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results;
  end
  initial begin
    rst(2'b00, 1);
    rreg(8'h00, 32'h2000, "ctrl");
    rreg(8'h0c, 0, "unmapped");
    chk("fast_en", fast_en, 0);
    @(posedge clk_sys);
    pmc <= 2'b11;
    frs <= 0;
    @(negedge clk_sys);
    chk("fast_en_cfg", fast_en, 1);
    chk("range_low", hi, 0);
    @(posedge clk_sys);
    pmc <= 2'b10;
    frs <= 1;
    @(negedge clk_sys);
    chk("range_high", hi, 1);
    $display("reset test done");
    wreg(8'h04, 32'h5);
    wreg(8'h08, 32'h0fedcba9);
    wreg(8'h00, 32'h40);
    for (i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (roll[5:3] != i && n < 250);
      @(negedge clk_sys);
      chk("trim_seq", trim, i == 0 ? 5 : 8 + i);
    end
    wreg(8'h00, 32'h80);
    repeat (2) @(negedge clk_sys);
    i = trim;
    n = 0;
    repeat (400) @(negedge clk_sys) n += (trim !== i[3:0]);
    chk("dither_moves", n != 0, 1);
    wreg(8'h00, 0);
    repeat (2) @(negedge clk_sys);
    chk("trim_usr", trim, 5);
    $display("trim test done");
    wreg(8'h00, 32'h1);
    repeat (3) @(negedge clk_sys);
    chk("src_fast", src, 0);
    chk("fast_on", fast_en, 1);
    rreg(8'h00, 32'h800, "ctrl_fast");
    wreg(8'h00, 32'h101);
    repeat (3) @(negedge clk_sys);
    chk("src_pri", src, 2);
    @(posedge clk_sys) osc_on <= 0;
    wtrap(60);
    rreg(8'h00, 32'h908, "ctrl_fail");
    wreg(8'h00, 0);
    rreg(8'h00, 32'h800, "cf_clear");
    rst(2'b00, 0);
    @(posedge clk_sys) put_done <= 1;
    wtrap(20);
    $display("fail test done");
    for (i = 1; i < 3; i++) begin
      rst(i[1:0], 1);
      @(posedge clk_sys) osc_on <= 0;
      wreg(8'h00, 32'h1);
      repeat (60) @(negedge clk_sys);
      chk("osc_off_cfg", off, i == 1);
      chk("src_cfg", src, i == 1 ? 0 : 2);
      rreg(8'h00, i == 1 ? 32'h800 : 32'h2000, "ctrl_cfg");
    end
    $display("config test done");
    results;
  end
endmodule
